/* File: ptm_pkg.sv */
// Shared constants and types of the periodic interval timer.
// Assumes a 32-bit APB register port and a single 100 MHz clock.
package ptm_pkg;

    localparam int COUNT_W = 20;
    localparam int TALLY_W = 12;
    localparam int ADDR_W = 8;
    localparam int PRESCALE_DIV = 16;

    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_VALUE_ACK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_VALUE_IMAGE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h14;

    localparam int MODE_LIMIT_LSB = 0;
    localparam int MODE_TIMER_ON_BIT = 24;
    localparam int MODE_TICK_IRQ_ON_BIT = 25;
    localparam int STATUS_FLAG_BIT = 0;
    localparam int EVT_INTERVAL_BIT = 0;
    localparam int EVT_TALLY_WRAP_BIT = 1;
    localparam int EVT_W = 2;

    localparam logic [31:0] MODE_RESET = 32'h000f_ffff;
    localparam logic [31:0] MODE_WRITE_MASK = 32'h030f_ffff;
    localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    // Field layout of the mode register.
    typedef struct packed {
        logic [5:0] rsvd_hi;
        logic tick_irq_on;
        logic timer_on;
        logic [3:0] rsvd_mid;
        logic [COUNT_W-1:0] interval_limit;
    } ptm_mode_type;

    // Field layout shared by both interval value views.
    typedef struct packed {
        logic [TALLY_W-1:0] interval_tally;
        logic [COUNT_W-1:0] interval_count;
    } ptm_value_type;

    // APB request signals from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } ptm_apb_req_type;

endpackage

/* File: ptm_sync.sv */
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin may change at any time relative to clk.
`timescale 1ns/1ps
module ptm_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin_in,
    output logic level_out
);
    logic meta_r;
    logic stage2_r;
    logic stage3_r;
    logic level_r;

    // The first stage feeds only the second; the filter looks at stages two and three.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            stage2_r <= meta_r;
            stage3_r <= stage2_r;
            if (stage2_r == stage3_r) begin
                level_r <= stage3_r;
            end
        end
    end

    assign level_out = level_r;
endmodule

/* File: ptm_prescaler.sv */
// Divider that turns the master clock into a one-cycle timebase tick.
// Assumes hold comes from logic on the same clock.
`timescale 1ns/1ps
module ptm_prescaler #(
    parameter int DIV = ptm_pkg::PRESCALE_DIV
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hold,
    output logic tick
);
    import ptm_pkg::*;

    localparam int CNT_W = $clog2(DIV);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // Holding freezes the phase so a halt does not shorten the next interval.
    assign tick = !hold && (cnt_r == LAST);
    assign cnt_nxt = hold ? cnt_r : (tick ? '0 : cnt_r + CNT_W'(1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

/* File: ptm_timer.sv */
// Periodic interval timer: interval counter, tally, flag and APB registers.
// Assumes an APB master on clk and a debug-state pin from the core's domain.
//
// Operation
// R1 - Keep a 20-bit interval counter and a 12-bit completed-interval tally.
// R2 - Both counters advance only on the master clock divided by sixteen.
// R3 - Count up from zero; at the limit return to zero and bump tally.
// R4 - One period lasts the limit value plus one timebase ticks.
// R5 - Reaching the limit sets the flag; interrupt only with interrupt enable. The code also raises irq from masked event status bits.
// R6 - Writing a new limit never resets or restarts the counters.
// R7 - Acknowledging read returns both counts, then clears tally and flag.
// R8 - Returned tally counts intervals since the previous acknowledging read.
// R9 - Image read returns the same counts and changes nothing.
// R10 - Timer enable resets to zero and acts only while counter is zero.
// R11 - After disabling, count on to the limit, wrap, then stay stopped.
// R12 - Counting stops while the core is in debug state.
// R13 - Interrupt is flag AND interrupt enable, held until flag clears. The code also ORs in the masked event status bits.
// R14 - Tally wraps modulo 4096; interval during acknowledge joins next tally.
`timescale 1ns/1ps
module ptm_timer (
    input wire logic clk,
    input wire logic arst_n,
    input ptm_pkg::ptm_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_state,
    output logic irq
);
    import ptm_pkg::*;

    ptm_mode_type mode_r;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;
    logic [TALLY_W-1:0] tally_r;
    logic [TALLY_W-1:0] tally_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [EVT_W-1:0] evt_r;
    logic [EVT_W-1:0] evt_nxt;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] mask_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    ptm_value_type value_nxt;
    ptm_mode_type mode_nxt;
    logic halt;
    logic tick;
    logic adv;
    logic wrap;

    wire setup = apb_req.psel && !apb_req.penable;
    wire access = apb_req.psel && apb_req.penable;
    wire hit_mode = apb_req.paddr == OFS_MODE;
    wire hit_status = apb_req.paddr == OFS_STATUS;
    wire hit_ack = apb_req.paddr == OFS_VALUE_ACK;
    wire hit_image = apb_req.paddr == OFS_VALUE_IMAGE;
    wire hit_evt = apb_req.paddr == OFS_EVENT_STATUS;
    wire hit_mask = apb_req.paddr == OFS_EVENT_MASK;
    wire mapped = hit_mode || hit_status || hit_ack || hit_image || hit_evt || hit_mask;
    wire wr_mode = access && apb_req.pwrite && hit_mode;
    wire wr_evt = access && apb_req.pwrite && hit_evt;
    wire wr_mask = access && apb_req.pwrite && hit_mask;
    wire ack_rd = access && !apb_req.pwrite && hit_ack;
    wire image_rd = access && !apb_req.pwrite && hit_image;

    ptm_sync u_debug_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(debug_state),
        .level_out(halt)
    );

    ptm_prescaler #(
        .DIV(PRESCALE_DIV)
    ) u_prescaler (
        .clk(clk),
        .arst_n(arst_n),
        .hold(halt),
        .tick(tick)
    );

    // The enable is only consulted at zero, so a running interval always completes.
    assign adv = tick && !halt && ((count_r != '0) || mode_r.timer_on); // see R2, R10, R11, R12
    assign wrap = adv && (count_r == mode_r.interval_limit); // see R4
    assign count_nxt = !adv ? count_r : (wrap ? '0 : count_r + COUNT_W'(1)); // see R1, R3

    // An interval ending on the acknowledge edge starts the next tally at one.
    assign tally_nxt = ack_rd ? (wrap ? TALLY_W'(1) : '0)
        : (wrap ? tally_r + TALLY_W'(1) : tally_r); // see R3, R7, R14
    assign flag_nxt = wrap || (flag_r && !ack_rd); // see R5, R7

    assign evt_set[EVT_INTERVAL_BIT] = wrap;
    assign evt_set[EVT_TALLY_WRAP_BIT] = wrap && (tally_r == '1);
    assign evt_nxt = evt_set | (evt_r & ~(wr_evt ? apb_req.pwdata[EVT_W-1:0] : '0));

    assign mode_nxt = wr_mode ? ptm_mode_type'(apb_req.pwdata & MODE_WRITE_MASK) : mode_r;
    assign value_nxt = '{interval_tally: tally_nxt, interval_count: count_nxt};

    // Read data is captured in the setup cycle from next-state values, so the
    // acknowledge edge only has to clear what was reported and keep that edge's wrap.
    assign rd_mux = hit_mode ? 32'(mode_nxt)
        : hit_status ? 32'(flag_nxt) << STATUS_FLAG_BIT
        : (hit_ack || hit_image) ? 32'(value_nxt) // see R7, R8, R9
        : hit_evt ? 32'(evt_nxt)
        : hit_mask ? 32'(mask_r)
        : 32'h0000_0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= ptm_mode_type'(MODE_RESET); // see R10
            count_r <= '0;
            tally_r <= '0;
            flag_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt; // see R6
            count_r <= count_nxt;
            tally_r <= tally_nxt;
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_r <= EVT_RESET;
            mask_r <= EVT_RESET;
            prdata_r <= VALUE_RESET;
        end else begin
            evt_r <= evt_nxt;
            if (wr_mask) begin
                mask_r <= apb_req.pwdata[EVT_W-1:0];
            end
            if (setup && !apb_req.pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign irq = (flag_r && mode_r.tick_irq_on) || ((evt_r & mask_r) != '0); // see R5, R13

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic [4:0] gap_cnt_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_cnt_r <= '0;
        end else if (adv) begin
            gap_cnt_r <= '0;
        end else if (!halt && gap_cnt_r != 5'h1f) begin
            gap_cnt_r <= gap_cnt_r + 5'h01;
        end
    end

    sequence s_ack_read;
        access && !apb_req.pwrite && hit_ack;
    endsequence

    sequence s_cleared;
        (tally_r == '0) && !flag_r;
    endsequence

    a_step_spacing: assert property (adv && $past(adv, 1) |-> 1'b0) // see R2
        else $error("interval counter advanced on two adjacent cycles");
    a_step_period: assert property (adv |-> (gap_cnt_r == 5'h0f) || $past(halt) || $past(halt, 2)
        || (gap_cnt_r == 5'h1f) || !$past(mode_r.timer_on, 16)) // see R2
        else $error("timebase tick spacing is not sixteen cycles");
    a_wrap_zero: assert property (wrap |=> count_r == '0
        && (tally_r != $past(tally_r) || $past(ack_rd))) // see R3
        else $error("counter did not wrap to zero with tally step at limit");
    a_count_step: assert property (adv && !wrap |=> count_r == $past(count_r) + COUNT_W'(1)) // see R3
        else $error("interval counter did not step by one");
    a_flag_set: assert property (wrap |=> flag_r) // see R5
        else $error("status flag not set when limit reached");
    a_irq_tie: assert property ((mask_r == '0) |-> irq == (flag_r && mode_r.tick_irq_on)) // see R13
        else $error("interrupt does not follow flag and enable");
    a_ack_clear: assert property (s_ack_read and !wrap |=> s_cleared) // see R7
        else $error("acknowledging read did not clear tally and flag");
    a_ack_keep: assert property (s_ack_read and wrap |=> tally_r == TALLY_W'(1) && flag_r) // see R14
        else $error("interval lost on acknowledging read");
    a_image_quiet: assert property (image_rd && !wrap |=> $stable(tally_r) && $stable(flag_r)) // see R9
        else $error("image read changed tally or flag");
    a_mode_no_restart: assert property (wr_mode && !adv |=> $stable(count_r) && $stable(tally_r)) // see R6
        else $error("mode write disturbed the counters");
    a_stay_stopped: assert property (count_r == '0 && !mode_r.timer_on |=> count_r == '0) // see R10, R11
        else $error("counter left zero while disabled");
    a_run_out: assert property (count_r != '0 && tick && !halt |-> adv) // see R11
        else $error("running interval did not count on to the limit");
    a_debug_freeze: assert property (halt && !ack_rd |=> $stable(count_r) && $stable(tally_r)) // see R12
        else $error("counters moved in debug state");
    a_ack_data: assert property (setup && !apb_req.pwrite && hit_ack |=>
        prdata_r == 32'($past(value_nxt))) // see R8
        else $error("acknowledging read data not the current counts");
endmodule

/* File: tb.sv */
// Self-checking bench for the periodic interval timer, driven over APB.
// Assumes ptm_pkg and ptm_timer are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module tb;
    import ptm_pkg::*;
    `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic debug_state = 1'b0;
    ptm_apb_req_type req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int t1, t2;
    logic [32:0] notes[$];
    logic [32:0] nt;
    logic [31:0] rnd;

    ptm_timer uut (.clk(clk), .arst_n(arst_n), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_state(debug_state), .irq(irq));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // Each read leaves its expected word and error flag behind; this process
    // checks them in order at the edge where the access phase completes.
    always @(posedge clk) begin
        if (req.psel && req.penable) begin
            `CHK("pready", 1'b1, pready)
            if (!req.pwrite && pready === 1'b1) begin
                nt = notes.pop_front();
                `CHK("prdata", nt[31:0], prdata)
                `CHK("pslverr", nt[32], pslverr)
            end
        end
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        notes.push_back({err, e});
        xfer(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        t = cyc;
        `CHK("irq_rise", 1'b1, irq)
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #100us;
        error_cnt++;
        test_done();
    end

    initial begin
        rnd = $urandom(32'h5132dbe5);
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (100) @(posedge clk);
        rd(OFS_MODE, MODE_RESET, 1'b0);
        rd(OFS_STATUS, 32'h0000_0000, 1'b0);
        rd(OFS_VALUE_ACK, VALUE_RESET, 1'b0);
        rd(OFS_VALUE_IMAGE, VALUE_RESET, 1'b0);
        rd(OFS_EVENT_MASK, 32'h0000_0000, 1'b0);
        rd(8'h18, 32'h0000_0000, 1'b1);
        // Counting must not start while the core is held in debug state.
        debug_state <= 1'b1;
        xfer(1'b1, OFS_EVENT_MASK, 32'h0000_0001);
        xfer(1'b1, OFS_MODE, 32'h0100_0003);
        repeat (100) @(posedge clk);
        rd(OFS_VALUE_IMAGE, 32'h0000_0000, 1'b0);
        debug_state <= 1'b0;
        wait_irq(t1);
        xfer(1'b1, OFS_EVENT_STATUS, 32'h0000_0001);
        `CHK("irq_clear", 1'b0, irq)
        wait_irq(t2);
        `CHK("period", 4 * PRESCALE_DIV, t2 - t1)
        xfer(1'b1, OFS_EVENT_MASK, 32'h0000_0000);
        // The random wait lands the disable well inside the fourth interval.
        repeat (78 + ($urandom % 30)) @(posedge clk);
        xfer(1'b1, OFS_MODE, 32'h0200_0003);
        xfer(1'b1, OFS_VALUE_IMAGE, $urandom);
        repeat (200) @(posedge clk);
        `CHK("irq_on", 1'b1, irq)
        rd(OFS_MODE, 32'h0200_0003, 1'b0);
        rd(OFS_VALUE_IMAGE, 32'h0040_0000, 1'b0);
        rd(OFS_VALUE_IMAGE, 32'h0040_0000, 1'b0);
        rd(OFS_STATUS, 32'h0000_0001, 1'b0);
        rd(OFS_EVENT_STATUS, 32'h0000_0001, 1'b0);
        rd(OFS_VALUE_ACK, 32'h0040_0000, 1'b0);
        rd(OFS_STATUS, 32'h0000_0000, 1'b0);
        rd(OFS_VALUE_ACK, 32'h0000_0000, 1'b0);
        `CHK("irq_ack", 1'b0, irq)
        repeat (200) @(posedge clk);
        rd(OFS_VALUE_IMAGE, 32'h0000_0000, 1'b0);
        repeat (3) @(posedge clk);
        test_done();
    end
endmodule
